// ### src/codec_port_pkg.sv
// Constants and types for the codec serial port core
package codec_port_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] ctrl_one_idx = 4'h0;
    localparam logic [3:0] ctrl_two_idx = 4'h1;
    localparam logic [3:0] status_idx = 4'h2;
    localparam int buf_base_pos = 3;

    // Control one field positions and masks
    localparam int port_enable_pos = 15;
    localparam int idle_stop_pos = 13;
    localparam int loopback_pos = 11;
    localparam int clock_dir_pos = 10;
    localparam int clock_edge_pos = 9;
    localparam int fs_dir_pos = 8;
    localparam int underflow_pos = 7;
    localparam int idle_out_mode_pos = 6;
    localparam int justify_pos = 5;
    localparam logic [15:0] ctrl_one_mask = 16'hafe3;
    localparam logic [15:0] ctrl_one_reset = 16'h0000;
    localparam logic [3:0] word_len_m1_reset = 4'hf;

    // Frame sync modes
    localparam logic [1:0] fs_multi_channel = 2'h0;
    localparam logic [1:0] fs_inter_ic = 2'h1;
    localparam logic [1:0] fs_link_16 = 2'h2;
    localparam logic [1:0] fs_link_20 = 2'h3;

    // Serial clock made here: half period in master clock cycles
    localparam logic [7:0] sck_half_cycles = 8'h04;
    localparam int sync_stages = 3;

    typedef struct packed {
        logic port_enable_bit;
        logic unused14;
        logic idle_stop_bit;
        logic unused12;
        logic loopback_bit;
        logic clock_direction_bit;
        logic clock_edge_select;
        logic frame_sync_direction_bit;
        logic underflow_mode_bit;
        logic idle_output_mode_bit;
        logic justification_bit;
        logic [2:0] unused4_2;
        logic [1:0] frame_sync_mode_field;
    } ctrl_one_type;

    typedef enum logic [0:0] {st_wait, st_word} engine_state_type;

endpackage : codec_port_pkg

// ### src/codec_serial_port_core.sv
// Codec serial port core: control, shadow buffers and serial engine
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module codec_serial_port_core
    import codec_port_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Processor state
    input wire logic cpu_idle,
    // Serial clock pin
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    // Serial data output pin
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe,
    // Serial data input pin
    input wire logic serial_in_pin_in,
    output logic serial_in_pin_oe,
    // Frame sync pin
    input wire logic frame_sync_pin_in,
    output logic frame_sync_pin_out,
    output logic frame_sync_pin_oe
);

    function automatic logic [2:0] buf_addr(input logic tx,
                                            input logic [1:0] cnt);
        buf_addr = {tx, cnt};
    endfunction : buf_addr

    // Pin synchronisers: clock, frame sync, data in
    logic [2:0] pin_in;
    logic [2:0] level_r;
    wire logic [2:0] level_nxt;
    assign pin_in = {serial_in_pin_in, frame_sync_pin_in,
                     serial_clock_pin_in};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            logic [sync_stages-1:0] sh_r;
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    sh_r <= '0;
                end else begin
                    sh_r <= {sh_r[sync_stages-2:0], pin_in[g]};
                end
            end
            // Only a level that two stages agree on counts
            assign level_nxt[g] = (sh_r[1] == sh_r[2]) ? sh_r[2]
                                                      : level_r[g];
        end
    endgenerate

    // Registers
    ctrl_one_type ctrl_r, ctrl_nxt;
    logic [3:0] wl_m1_r, wl_m1_nxt;
    logic [15:0] cpu_buf_r [8];
    logic [15:0] cpu_buf_nxt [8];
    logic [15:0] shadow_r [8];
    logic [15:0] shadow_nxt [8];
    logic [15:0] rdata_r, rdata_nxt;

    // Engine state
    engine_state_type state_r, state_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [1:0] addr_cnt_r, addr_cnt_nxt;
    logic [3:0] slot_cnt_r, slot_cnt_nxt;
    logic [7:0] div_r, div_nxt;
    logic sck_r, sck_nxt;
    logic sdo_r, sdo_nxt;
    logic fs_out_r, fs_out_nxt;
    logic fs_seen_r, fs_seen_nxt;
    logic pend_r, pend_nxt;
    logic en_d_r;

    logic en, run, int_clk, int_fs;
    logic sck_now, sck_prev, rise_ev, fall_ev;
    logic sample_ev, launch_ev, fs_now, fs_act, din;
    logic [15:0] rx_word;
    logic wrap;
    logic tick;

    assign en = ctrl_r.port_enable_bit;
    assign run = en && !(ctrl_r.idle_stop_bit && cpu_idle);
    assign int_clk = !ctrl_r.clock_direction_bit;
    assign int_fs = !ctrl_r.frame_sync_direction_bit;
    // Divider toggle is decoded apart, so edge detection never loops
    assign tick = run && int_clk && (div_r == sck_half_cycles - 8'h01);

    // Serial clock edges, from the divider or the pin
    assign sck_now = int_clk ? (sck_r ^ tick) : level_nxt[0];
    assign sck_prev = int_clk ? sck_r : level_r[0];
    assign rise_ev = run && sck_now && !sck_prev;
    assign fall_ev = run && !sck_now && sck_prev;
    assign sample_ev = ctrl_r.clock_edge_select ? rise_ev : fall_ev;
    assign launch_ev = ctrl_r.clock_edge_select ? fall_ev : rise_ev;

    // I2S word select pulses low for one bit at slot zero; other modes pulse high
    assign fs_act = (ctrl_r.frame_sync_mode_field == fs_inter_ic)
                    ? 1'b0 : 1'b1;
    assign fs_now = int_fs ? (slot_cnt_r == 4'h0) : fs_seen_r;
    assign din = ctrl_r.loopback_bit ? sdo_r : level_r[2];
    assign rx_word = {shift_r[14:0], din} << (4'hf - bit_cnt_r);
    assign wrap = (addr_cnt_r == 2'h3);

    always_comb begin
        ctrl_nxt = ctrl_r;
        wl_m1_nxt = wl_m1_r;
        rdata_nxt = 16'h0000;
        cpu_buf_nxt = cpu_buf_r;
        shadow_nxt = shadow_r;
        state_nxt = state_r;
        shift_nxt = shift_r;
        bit_cnt_nxt = bit_cnt_r;
        addr_cnt_nxt = addr_cnt_r;
        slot_cnt_nxt = slot_cnt_r;
        div_nxt = div_r;
        sck_nxt = sck_r;
        sdo_nxt = sdo_r;
        fs_out_nxt = fs_out_r;
        fs_seen_nxt = fs_seen_r;
        pend_nxt = pend_r;

        // Register port
        if (reg_wr) begin
            if (reg_addr == ctrl_one_idx) begin
                ctrl_nxt = reg_wdata & ctrl_one_mask;
            end else if (reg_addr == ctrl_two_idx) begin
                wl_m1_nxt = reg_wdata[3:0];
            end else if (reg_addr[buf_base_pos] && reg_addr[2]) begin
                cpu_buf_nxt[reg_addr[2:0]] = reg_wdata;
            end
        end
        if (reg_rd) begin
            if (reg_addr == ctrl_one_idx) begin
                rdata_nxt = ctrl_r;
            end else if (reg_addr == ctrl_two_idx) begin
                rdata_nxt = {12'h000, wl_m1_r};
            end else if (reg_addr == status_idx) begin
                rdata_nxt = {13'h0, state_r == st_word, addr_cnt_r};
            end else if (reg_addr[buf_base_pos]) begin
                rdata_nxt = cpu_buf_r[reg_addr[2:0]];
            end
        end

        if (!en) begin
            // Disabled port holds its place at slot zero
            state_nxt = st_wait;
            addr_cnt_nxt = 2'h0;
            slot_cnt_nxt = 4'h0;
            div_nxt = 8'h00;
            sck_nxt = 1'b0;
            sdo_nxt = 1'b0;
            fs_out_nxt = !fs_act;
            fs_seen_nxt = 1'b0;
            pend_nxt = 1'b0;
        end else begin
            if (!en_d_r) begin
                for (int i = 0; i < 4; i++) begin
                    shadow_nxt[buf_addr(1'b1, i[1:0])] =
                        cpu_buf_r[buf_addr(1'b1, i[1:0])];
                end
            end
            if (run && int_clk) begin
                if (tick) begin
                    div_nxt = 8'h00;
                    sck_nxt = !sck_r;
                end else begin
                    div_nxt = div_r + 8'h01;
                end
            end
            if (sample_ev && !int_fs) begin
                fs_seen_nxt = (level_r[1] == fs_act);
            end
            if (launch_ev) begin
                if (int_fs) begin
                    fs_out_nxt = (slot_cnt_r == 4'h0) ? fs_act : !fs_act;
                    slot_cnt_nxt = slot_cnt_r + 4'h1;
                end
                if ((fs_now && ctrl_r.justification_bit) || pend_r) begin
                    // Word begins: load transmit slot into shift register
                    shift_nxt = shadow_r[buf_addr(1'b1, addr_cnt_r)];
                    sdo_nxt = shift_nxt[15];
                    bit_cnt_nxt = 4'h0;
                    state_nxt = st_word;
                    pend_nxt = 1'b0;
                end else begin
                    pend_nxt = fs_now && !ctrl_r.justification_bit;
                    if (state_r == st_word) begin
                        sdo_nxt = shift_r[15];
                    end
                end
            end
            if (sample_ev && state_r == st_word) begin
                shift_nxt = {shift_r[14:0], din};
                bit_cnt_nxt = bit_cnt_r + 4'h1;
                if (bit_cnt_r == wl_m1_r) begin
                    // Stop after word length: unused low bits never go out
                    state_nxt = st_wait;
                    shadow_nxt[buf_addr(1'b0, addr_cnt_r)] = rx_word;
                    addr_cnt_nxt = addr_cnt_r + 2'h1;
                    if (wrap) begin
                        // Swap halves only at a full pass, so software
                        // sees a whole set of words at once
                        for (int i = 0; i < 4; i++) begin
                            cpu_buf_nxt[buf_addr(1'b0, i[1:0])] =
                                shadow_nxt[buf_addr(1'b0, i[1:0])];
                            shadow_nxt[buf_addr(1'b1, i[1:0])] =
                                cpu_buf_nxt[buf_addr(1'b1, i[1:0])];
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            level_r <= 3'h0;
            ctrl_r <= ctrl_one_reset;
            wl_m1_r <= word_len_m1_reset;
            rdata_r <= 16'h0000;
            for (int i = 0; i < 8; i++) begin
                cpu_buf_r[i] <= 16'h0000;
                shadow_r[i] <= 16'h0000;
            end
            state_r <= st_wait;
            shift_r <= 16'h0000;
            bit_cnt_r <= 4'h0;
            addr_cnt_r <= 2'h0;
            slot_cnt_r <= 4'h0;
            div_r <= 8'h00;
            sck_r <= 1'b0;
            sdo_r <= 1'b0;
            fs_out_r <= 1'b0;
            fs_seen_r <= 1'b0;
            pend_r <= 1'b0;
            en_d_r <= 1'b0;
        end else begin
            level_r <= level_nxt;
            ctrl_r <= ctrl_nxt;
            wl_m1_r <= wl_m1_nxt;
            rdata_r <= rdata_nxt;
            cpu_buf_r <= cpu_buf_nxt;
            shadow_r <= shadow_nxt;
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            addr_cnt_r <= addr_cnt_nxt;
            slot_cnt_r <= slot_cnt_nxt;
            div_r <= div_nxt;
            sck_r <= sck_nxt;
            sdo_r <= sdo_nxt;
            fs_out_r <= fs_out_nxt;
            fs_seen_r <= fs_seen_nxt;
            pend_r <= pend_nxt;
            en_d_r <= en;
        end
    end

    // Pins
    assign reg_rdata = rdata_r;
    assign serial_clock_pin_out = sck_r;
    assign serial_clock_pin_oe = en && int_clk;
    assign serial_out_pin_out = (state_r == st_word) ? sdo_r : 1'b0;
    assign serial_out_pin_oe = en && ((state_r == st_word) ||
                               !ctrl_r.idle_output_mode_bit);
    assign serial_in_pin_oe = 1'b0;
    assign frame_sync_pin_out = fs_out_r;
    assign frame_sync_pin_oe = en && int_fs;

endmodule : codec_serial_port_core
`default_nettype wire

// ### testbench/codec_partner.sv
// Behavioural codec on the far side of the serial pins
`timescale 1ns/10ps
`default_nettype none
module codec_partner (
    // Bench control
    input wire logic run,
    input wire logic [63:0] words_out,
    output logic [63:0] words_in,
    // Serial pins
    output logic sck,
    output logic fs,
    output logic sdi,
    input wire logic sdo
);
    int w;
    int b;
    initial begin
        sck = 1'b1;
        fs = 1'b0;
        sdi = 1'b0;
        words_in = '0;
    end
    // A released data line must not hold its last bit
    always #37 if (!run) sdi = ~sdi;
    always begin
        wait (run);
        // Offset keeps pin edges off the master clock edges
        #1.3;
        // Lead-in clock: sync is sampled one edge before the first bit
        fs = 1'b1;
        sck = 1'b0;
        #62.5;
        sck = 1'b1;
        #62.5;
        w = 0;
        while (run) begin
            for (b = 0; b < 16; b++) begin
                sck = 1'b0;
                fs = (b == 15);
                sdi = words_out[w*16+15-b];
                #62.5;
                sck = 1'b1;
                words_in[w*16+15-b] = sdo;
                #62.5;
            end
            w = (w + 1) % 4;
        end
        fs = 1'b0;
    end
endmodule : codec_partner
`default_nettype wire

// ### testbench/codec_serial_port_core_asserts.sv
// Checker for the codec serial port pins and register port
`timescale 1ns/10ps
`default_nettype none
module codec_port_checker
    import codec_port_pkg::*;
(
    // Clock, reset, register port
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic cpu_idle,
    // Pins
    input wire logic serial_clock_pin_out,
    input wire logic serial_clock_pin_oe,
    input wire logic serial_out_pin_oe,
    input wire logic serial_in_pin_oe,
    input wire logic frame_sync_pin_oe
);
    logic [15:0] ctl_r, ctl_nxt;
    logic [3:0] calm_r, calm_nxt;
    logic on;
    logic spin;
    // Pin enables may lag a control write, so judge them once it settled
    assign on = ctl_r[port_enable_pos] && calm_r > 4'h3;
    // Internal serial clock is expected to move
    assign spin = on && !ctl_r[clock_dir_pos] &&
                  !(ctl_r[idle_stop_pos] && cpu_idle);
    always_comb begin
        ctl_nxt = ctl_r;
        calm_nxt = (calm_r == 4'hf) ? calm_r : calm_r + 4'h1;
        if (reg_wr && reg_addr == ctrl_one_idx) begin
            ctl_nxt = reg_wdata & ctrl_one_mask;
            calm_nxt = 4'h0;
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_r <= ctrl_one_reset;
            calm_r <= 4'h0;
        end else begin
            ctl_r <= ctl_nxt;
            calm_r <= calm_nxt;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_clock_pin_dir: assert property (on |->
        serial_clock_pin_oe == !ctl_r[clock_dir_pos])
        else $error("clock pin direction wrong");
    a_frame_pin_dir: assert property (on |->
        frame_sync_pin_oe == !ctl_r[fs_dir_pos])
        else $error("frame sync pin direction wrong");
    a_input_only: assert property (!serial_in_pin_oe)
        else $error("data input pin driven");
    a_released_off: assert property (!ctl_r[port_enable_pos] &&
        calm_r > 4'h3 |-> !serial_clock_pin_oe && !serial_out_pin_oe &&
        !frame_sync_pin_oe)
        else $error("disabled port drives a pin");
    a_out_low_idle: assert property (on && !ctl_r[idle_out_mode_pos]
        |-> serial_out_pin_oe)
        else $error("data out not driven in low mode");
    a_read_idle_zero: assert property (!$past(reg_rd) |->
        reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    a_ctrl_readback: assert property ($past(reg_rd) &&
        $past(reg_addr) == ctrl_one_idx |-> reg_rdata == $past(ctl_r))
        else $error("control one read back wrong");
    // Four running divider cycles hold exactly one toggle
    a_clock_runs: assert property (spin [*5] |->
        serial_clock_pin_out != $past(serial_clock_pin_out, 4))
        else $error("internal serial clock stalled");
    a_idle_halts: assert property ((on && ctl_r[idle_stop_pos] &&
        cpu_idle) [*4] |-> $stable(serial_clock_pin_out))
        else $error("serial clock runs in idle stop");
endmodule : codec_port_checker
bind codec_serial_port_core codec_port_checker chk_u (.mclk(mclk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_idle(cpu_idle), .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe(serial_clock_pin_oe),
    .serial_out_pin_oe(serial_out_pin_oe),
    .serial_in_pin_oe(serial_in_pin_oe),
    .frame_sync_pin_oe(frame_sync_pin_oe));
`default_nettype wire

// ### testbench/codec_serial_port_core_tb.sv
// Self-checking bench for the codec serial port core
`timescale 1ns/10ps
`default_nettype none
module codec_serial_port_core_tb
    import codec_port_pkg::*;
;
    typedef struct packed {
        logic [15:0] ctl;
        logic [3:0] oe;
    } row_type;
    row_type rows [6] = '{'{16'h0000, 4'h0}, '{16'h7fff, 4'h0},
        '{16'h8000, 4'hd}, '{16'h8100, 4'hc}, '{16'h8500, 4'h4},
        '{16'h8540, 4'h0}};
    logic mclk, reset_n, reg_wr, reg_rd, cpu_idle, run;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic sck_o, sck_oe, sdo_o, sdo_oe, sdi_oe, fs_o, fs_oe;
    logic p_sck, p_fs, p_sdi;
    logic [63:0] p_in;
    logic [63:0] tx_w = 64'h7ffe_8001_0f1e_a5c3;
    int num_errors = 0;
    int num_checks = 0;
    wire sck_w = sck_oe ? sck_o : p_sck;
    wire fs_w = fs_oe ? fs_o : p_fs;
    codec_serial_port_core dut_u (.mclk(mclk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle),
        .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
        .serial_clock_pin_oe(sck_oe), .serial_out_pin_out(sdo_o),
        .serial_out_pin_oe(sdo_oe), .serial_in_pin_in(p_sdi),
        .serial_in_pin_oe(sdi_oe), .frame_sync_pin_in(fs_w),
        .frame_sync_pin_out(fs_o), .frame_sync_pin_oe(fs_oe));
    codec_partner codec_u (.run(run), .words_out(~tx_w), .words_in(p_in),
        .sck(p_sck), .fs(p_fs), .sdi(p_sdi),
        .sdo(sdo_oe ? sdo_o : 1'b1));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("register %h", a), exp, reg_rdata);
    endtask : rd
    task automatic xfer(input logic [15:0] ctl, input logic [15:0] len,
        input logic [15:0] keep, input logic [63:0] rx);
        wr(ctrl_one_idx, 16'h0000);
        wr(ctrl_two_idx, len);
        for (int i = 0; i < 4; i++) wr(4'hc + i[3:0], tx_w[i*16 +: 16]);
        wr(ctrl_one_idx, ctl);
        run <= 1'b1;
        repeat (1100) @(posedge mclk);
        run <= 1'b0;
        repeat (300) @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            check("codec word", tx_w[i*16 +: 16] & keep, p_in[i*16 +: 16]);
            rd(4'h8 + i[3:0], rx[i*16 +: 16] & keep);
        end
    endtask : xfer
    task automatic toggles(input logic [15:0] ctl, input logic [15:0] exp);
        logic [15:0] n;
        logic last;
        n = 16'h0000;
        wr(ctrl_one_idx, ctl);
        repeat (8) @(posedge mclk);
        #1;
        last = sck_o;
        repeat (40) begin
            @(posedge mclk);
            #1;
            if (sck_o !== last) n++;
            last = sck_o;
        end
        check("clock edges", exp, n);
    endtask : toggles
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        cpu_idle = 1'b0;
        run = 1'b0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        rd(ctrl_one_idx, ctrl_one_reset);
        rd(ctrl_two_idx, {12'h000, word_len_m1_reset});
        $display("test reset done");
        foreach (rows[i]) begin
            // Each row starts from a disabled port, so no word is left open
            wr(ctrl_one_idx, 16'h0000);
            wr(ctrl_one_idx, rows[i].ctl);
            repeat (4) @(posedge mclk);
            #1;
            check("pin enables", {12'h000, rows[i].oe},
                {12'h000, sck_oe, sdo_oe, sdi_oe, fs_oe});
            rd(ctrl_one_idx, rows[i].ctl & ctrl_one_mask);
        end
        $display("test pin directions done");
        xfer(16'h8720, 16'h000f, 16'hffff, ~tx_w);
        wr(4'h8, 16'hffff);
        rd(4'h8, ~tx_w[15:0]);
        rd(4'h3, 16'h0000);
        $display("test word transfer done");
        xfer(16'h8f20, 16'h0007, 16'hff00, tx_w);
        $display("test loopback done");
        @(posedge mclk);
        cpu_idle <= 1'b1;
        toggles(16'ha000, 16'h0000);
        toggles(16'h8000, 16'h000a);
        wr(ctrl_one_idx, 16'h0000);
        rd(status_idx, 16'h0000);
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd(ctrl_one_idx, ctrl_one_reset);
        $display("test idle and disable done");
        test_done();
    end
endmodule : codec_serial_port_core_tb
`default_nettype wire
